// ===== hw/swc_defines.vh
// Constants for the sleep/wake controller: offsets, fields, vector, timing.
// Assumes inclusion by bare name from the design files.
`ifndef SWC_DEFINES_VH
`define SWC_DEFINES_VH
// Register byte offsets
`define SWC_CTRL_OFF      12'h000
`define SWC_STATUS_OFF    12'h004
`define SWC_IRQEN_OFF     12'h008
`define SWC_IRQFLG_OFF    12'h00c
`define SWC_WDTCNT_OFF    12'h010
`define SWC_PIN_OFF       12'h014
// Status fields
`define SWC_PDF_BIT       3
`define SWC_TOF_BIT       4
`define SWC_ASLEEP_BIT    0
`define SWC_OSCON_BIT     1
// Control fields
`define SWC_WDTEN_BIT     0
`define SWC_GIE_BIT       1
// Wake source indices: ext pin, pin change, eight peripherals
`define SWC_NSRC          10
`define SWC_VECTOR        13'h0004
`define SWC_WDT_LIMIT     16'h0fff
`define SWC_NPIN          8
`endif

// ===== hw/swc_pin_hold.v
// Holds the I/O pin state (level and drive enable) frozen across power-down.
// Assumes the main file asserts freeze for the whole sleep period.
`timescale 1ns/1ps
module swc_pin_hold #(
   parameter NPIN = 8
) (
   // Clock and reset
   input  wire            core_clk,
   input  wire            nrst,
   // Live pin control
   input  wire            freeze,
   input  wire [NPIN-1:0] liveOut,
   input  wire [NPIN-1:0] liveOe,
   // Held pin control
   output reg  [NPIN-1:0] pinOut_ff,
   output reg  [NPIN-1:0] pinOe_ff
);
   genvar i;
   generate
      for (i = 0; i < NPIN; i = i + 1) begin : g_pin
         always @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
               pinOut_ff[i] <= 1'b0;
               pinOe_ff[i]  <= 1'b0;
            end else if (!freeze) begin
               pinOut_ff[i] <= liveOut[i];
               pinOe_ff[i]  <= liveOe[i];
            end
         end
      end
   endgenerate
endmodule // swc_pin_hold

// ===== hw/swc_sleep_ctrl.v
// Sleep/wake controller with APB registers, watchdog and pin hold.
// Assumes a single core_clk that models the always-running watchdog clock.
`timescale 1ns/1ps
`include "swc_defines.vh"

module swc_sleep_ctrl #(
   parameter NPIN = `SWC_NPIN,
   parameter PCW  = 13
) (
   // Clock and reset
   input  wire                  core_clk,
   input  wire                  nrst,
   // APB slave
   input  wire                  psel,
   input  wire                  penable,
   input  wire                  pwrite,
   input  wire [11:0]           paddr,
   input  wire [31:0]           pwdata,
   output reg  [31:0]           prdata_ff,
   output reg                   pready_ff,
   output reg                   pslverr_ff,
   // Pipeline
   input  wire                  sleepExec,
   input  wire                  wdtClearExec,
   input  wire [PCW-1:0]        programCounter,
   output reg  [PCW-1:0]        fetchAddr_ff,
   output reg                   fetchValid_ff,
   output reg                   vectorTake_ff,
   output reg                   coreRun_ff,
   // Power and resets
   input  wire                  extResetPinN,
   output reg                   oscDriveEn_ff,
   output reg                   wdtReset_ff,
   output reg                   deviceReset_ff,
   // Interrupt sources: ext pin, pin change, 8 async-capable peripherals
   input  wire [`SWC_NSRC-1:0]  irqFlag,
   input  wire [`SWC_NSRC-1:0]  irqAsyncOk,
   // I/O pins
   input  wire [NPIN-1:0]       liveOut,
   input  wire [NPIN-1:0]       liveOe,
   output wire [NPIN-1:0]       pinOut,
   output wire [NPIN-1:0]       pinOe
);
   localparam ST_AWAKE = 3'b001;
   localparam ST_SLEEP = 3'b010;
   localparam ST_WAKE  = 3'b100;

   reg [2:0]              state_ff,  nxt_state;
   reg                    pdFlag_ff, nxt_pdFlag;
   reg                    toFlag_ff, nxt_toFlag;
   reg                    wdtEn_ff;
   reg                    gie_ff;
   reg [`SWC_NSRC-1:0]    irqEn_ff;
   reg [15:0]             wdtCnt_ff, nxt_wdtCnt;
   reg                    wakeByWdt;
   reg                    rstSync1_ff, rstSync2_ff;

   wire apbWr = psel && penable && pwrite;
   wire asleep = state_ff[1];

   function hitOff;
      input [11:0] a;
      input [11:0] off;
      begin
         hitOff = (a == off);
      end
   endfunction

   wire [`SWC_NSRC-1:0] srcLive = irqFlag & irqEn_ff & (asleep ? irqAsyncOk
                                                                : {`SWC_NSRC{1'b1}});
   wire irqPending = |srcLive;
   wire wdtExpire = wdtEn_ff && (wdtCnt_ff == `SWC_WDT_LIMIT);
   // Pin is synchronised; the second stage alone is looked at
   wire extRstSeen = !rstSync2_ff;

   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rstSync1_ff <= 1'b1;
         rstSync2_ff <= 1'b1;
      end else begin
         rstSync1_ff <= extResetPinN;
         rstSync2_ff <= rstSync1_ff;
      end
   end

   always @* begin
      nxt_state  = state_ff;
      nxt_pdFlag = pdFlag_ff;
      nxt_toFlag = toFlag_ff;
      nxt_wdtCnt = wdtEn_ff ? wdtCnt_ff + 16'h0001 : 16'h0000;
      wakeByWdt  = 1'b0;
      if (wdtClearExec) begin
         nxt_wdtCnt = 16'h0000;
      end
      case (state_ff)
         ST_AWAKE: begin
            // pending interrupt turns sleep into no-op
            if (sleepExec && !irqPending) begin
               // clear watchdog count, keep it running
               nxt_wdtCnt = 16'h0000;
               // power-down flag cleared by real sleep
               nxt_pdFlag = 1'b0;
               nxt_toFlag = 1'b1;
               nxt_state  = ST_SLEEP;
            end else if (wdtExpire) begin
               nxt_wdtCnt = 16'h0000;
               nxt_toFlag = 1'b0;
            end
         end
         ST_SLEEP: begin
            // late interrupt wakes right after entry
            if (irqPending) begin
               nxt_state = ST_WAKE;
            end else if (wdtExpire) begin
               wakeByWdt  = 1'b1;
               nxt_toFlag = 1'b0;
               nxt_wdtCnt = 16'h0000;
               nxt_state  = ST_WAKE;
            end
         end
         ST_WAKE: begin
            nxt_state = ST_AWAKE;
         end
         default: begin
            nxt_state = ST_AWAKE;
         end
      endcase
   end

   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_ff      <= ST_AWAKE;
         oscDriveEn_ff <= 1'b1;
         coreRun_ff    <= 1'b1;
         pdFlag_ff     <= 1'b1;
         toFlag_ff     <= 1'b1;
         wdtCnt_ff     <= 16'h0000;
         wdtReset_ff   <= 1'b0;
         deviceReset_ff <= 1'b0;
         fetchAddr_ff  <= {PCW{1'b0}};
         fetchValid_ff <= 1'b0;
         vectorTake_ff <= 1'b0;
      end else if (extRstSeen) begin
         // reset pin gives device reset; wdtEn_ff, gie_ff and irqEn_ff keep their values
         state_ff       <= ST_AWAKE;
         oscDriveEn_ff  <= 1'b1;
         coreRun_ff     <= 1'b0;
         pdFlag_ff      <= 1'b1;
         toFlag_ff      <= 1'b1;
         wdtCnt_ff      <= 16'h0000;
         wdtReset_ff    <= 1'b0;
         deviceReset_ff <= 1'b1;
         fetchAddr_ff   <= {PCW{1'b0}};
         fetchValid_ff  <= 1'b0;
         vectorTake_ff  <= 1'b0;
      end else begin
         state_ff       <= nxt_state;
         pdFlag_ff      <= nxt_pdFlag;
         toFlag_ff      <= nxt_toFlag;
         wdtCnt_ff      <= nxt_wdtCnt;
         deviceReset_ff <= 1'b0;
         oscDriveEn_ff  <= (nxt_state != ST_SLEEP);
         coreRun_ff     <= (nxt_state != ST_SLEEP);
         // Awake expiry is a watchdog reset, asleep expiry is not
         wdtReset_ff    <= (state_ff == ST_AWAKE) && wdtExpire
                           && !(sleepExec && !irqPending);
         fetchValid_ff  <= (state_ff == ST_AWAKE) && sleepExec;
         if ((state_ff == ST_AWAKE) && sleepExec) begin
            fetchAddr_ff <= programCounter + {{(PCW-1){1'b0}}, 1'b1};
         end
         // run next instruction, then vector if enabled
         vectorTake_ff  <= (state_ff == ST_WAKE) && gie_ff && !wakeByWdt
                           && (toFlag_ff == 1'b1);
      end
   end

   swc_pin_hold #(
      .NPIN(NPIN)
   ) u_pin_hold (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .freeze    (asleep),
      .liveOut   (liveOut),
      .liveOe    (liveOe),
      .pinOut_ff (pinOut),
      .pinOe_ff  (pinOe)
   );

   // APB registers
   wire mapped = hitOff(paddr, `SWC_CTRL_OFF) || hitOff(paddr, `SWC_STATUS_OFF)
              || hitOff(paddr, `SWC_IRQEN_OFF) || hitOff(paddr, `SWC_IRQFLG_OFF)
              || hitOff(paddr, `SWC_WDTCNT_OFF) || hitOff(paddr, `SWC_PIN_OFF);

   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         wdtEn_ff   <= 1'b0;
         gie_ff     <= 1'b0;
         irqEn_ff   <= {`SWC_NSRC{1'b0}};
         prdata_ff  <= 32'h00000000;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff  <= psel && !penable;
         pslverr_ff <= psel && !penable && !mapped;
         if (apbWr && pready_ff && hitOff(paddr, `SWC_CTRL_OFF)) begin
            wdtEn_ff <= pwdata[`SWC_WDTEN_BIT];
            gie_ff   <= pwdata[`SWC_GIE_BIT];
         end
         if (apbWr && pready_ff && hitOff(paddr, `SWC_IRQEN_OFF)) begin
            irqEn_ff <= pwdata[`SWC_NSRC-1:0];
         end
         prdata_ff <= 32'h00000000;
         if (psel && !penable && !pwrite) begin
            if (hitOff(paddr, `SWC_CTRL_OFF)) begin
               prdata_ff <= {30'h0, gie_ff, wdtEn_ff};
            end else if (hitOff(paddr, `SWC_STATUS_OFF)) begin
               prdata_ff <= {27'h0, toFlag_ff, pdFlag_ff, 1'b0, oscDriveEn_ff, asleep};
            end else if (hitOff(paddr, `SWC_IRQEN_OFF)) begin
               prdata_ff <= {22'h0, irqEn_ff};
            end else if (hitOff(paddr, `SWC_IRQFLG_OFF)) begin
               prdata_ff <= {22'h0, irqFlag};
            end else if (hitOff(paddr, `SWC_WDTCNT_OFF)) begin
               prdata_ff <= {16'h0, wdtCnt_ff};
            end else if (hitOff(paddr, `SWC_PIN_OFF)) begin
               prdata_ff <= {16'h0, pinOe, pinOut};
            end
         end
      end
   end

endmodule // swc_sleep_ctrl

// ===== verif/swc_checker.sv
// Port-level properties of the sleep/wake controller.
// Assumes one clock domain; bound into every swc_sleep_ctrl.
`timescale 1ns/1ps
module swc_checker (
   // Clock, reset and bus
   input wire        core_clk, nrst, psel, penable, pready_ff, pslverr_ff,
   // Pipeline and power
   input wire        sleepExec, fetchValid_ff, vectorTake_ff, coreRun_ff, extResetPinN,
   input wire        oscDriveEn_ff, wdtReset_ff, deviceReset_ff,
   input wire [12:0] programCounter, fetchAddr_ff,
   // Held pins
   input wire [7:0]  pinOut, pinOe
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   osc_stop_cause_a: assert property ($fell(oscDriveEn_ff) |-> $past(sleepExec))
      else $error("oscillator stopped without sleep");
   prefetch_addr_a: assert property (fetchValid_ff |->
      $past(sleepExec) && fetchAddr_ff == $past(programCounter) + 13'h1)
      else $error("prefetch address wrong");
   core_stopped_a: assert property (!oscDriveEn_ff |-> !coreRun_ff)
      else $error("core runs while oscillator off");
   pins_frozen_a: assert property (!oscDriveEn_ff && !$past(oscDriveEn_ff) |->
      $stable(pinOut) && $stable(pinOe)) else $error("pins moved while asleep");
   pin_reset_a: assert property ($fell(extResetPinN) |-> ##[1:6] deviceReset_ff)
      else $error("reset pin ignored");
   reset_awake_a: assert property (deviceReset_ff |-> oscDriveEn_ff)
      else $error("oscillator off in reset");
   apb_answer_a: assert property (psel && !penable |=> pready_ff ##1 !pready_ff)
      else $error("bus answer not one cycle");
   slverr_ready_a: assert property (pslverr_ff |-> pready_ff)
      else $error("error without ready");
   vector_pulse_a: assert property (vectorTake_ff |-> oscDriveEn_ff ##1 !vectorTake_ff)
      else $error("vector pulse wrong");
   wdt_awake_a: assert property (wdtReset_ff |-> $past(oscDriveEn_ff))
      else $error("watchdog reset from sleep");
endmodule // swc_checker
bind swc_sleep_ctrl swc_checker chk (
   .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pready_ff(pready_ff),
   .pslverr_ff(pslverr_ff), .sleepExec(sleepExec), .fetchValid_ff(fetchValid_ff),
   .vectorTake_ff(vectorTake_ff), .coreRun_ff(coreRun_ff), .extResetPinN(extResetPinN),
   .oscDriveEn_ff(oscDriveEn_ff), .wdtReset_ff(wdtReset_ff), .deviceReset_ff(deviceReset_ff),
   .programCounter(programCounter), .fetchAddr_ff(fetchAddr_ff), .pinOut(pinOut),
   .pinOe(pinOe));

// ===== verif/swc_pipe_model.sv
// Pipeline partner: issues watchdog clear then sleep; interrupt sources.
// Assumes the bench requests a sleep by a one-cycle go pulse.
`timescale 1ns/1ps
module swc_pipe_model (
   input  wire        core_clk, go,
   input  wire [12:0] pc,
   input  wire [9:0]  fire, asyncOk,
   output reg         sleepExec, wdtClearExec,
   output reg  [12:0] programCounter,
   output reg  [9:0]  irqFlag, irqAsyncOk
);
   initial {sleepExec, wdtClearExec, programCounter, irqFlag, irqAsyncOk} = 0;
   always @(posedge core_clk) begin
      wdtClearExec   <= go;
      sleepExec      <= wdtClearExec;
      // Address is only meaningful with sleepExec
      programCounter <= wdtClearExec ? pc : ~programCounter;
      irqAsyncOk     <= asyncOk;
      // Raw flags: masking clocked sources asleep is the design's job
      irqFlag        <= fire;
   end
endmodule // swc_pipe_model

// ===== verif/tb_sleep_wake_controller.sv
// Bench for the sleep/wake controller: APB tasks, random sleep/wake runs.
// Assumes swc_pipe_model as pipeline partner and the bound checker.
`timescale 1ns/1ps
`include "swc_defines.vh"
module tb_sleep_wake_controller;
   reg         core_clk, nrst, psel, penable, pwrite, go, extResetPinN, er, sawVec;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, rd, seed;
   reg  [12:0] pc;
   reg  [9:0]  fire, asyncOk;
   reg  [7:0]  liveOut, liveOe;
   reg  [15:0] held;
   wire [31:0] prdata_ff;
   wire [12:0] programCounter, fetchAddr_ff;
   wire [9:0]  irqFlag, irqAsyncOk;
   wire [7:0]  pinOut, pinOe;
   wire        pready_ff, pslverr_ff, sleepExec, wdtClearExec, fetchValid_ff;
   wire        vectorTake_ff, coreRun_ff, oscDriveEn_ff, wdtReset_ff, deviceReset_ff;
   integer     mismatches, cmp_count, i, k;
   swc_sleep_ctrl dut (
      .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
      .pslverr_ff(pslverr_ff), .sleepExec(sleepExec), .wdtClearExec(wdtClearExec),
      .programCounter(programCounter), .fetchAddr_ff(fetchAddr_ff),
      .fetchValid_ff(fetchValid_ff), .vectorTake_ff(vectorTake_ff), .coreRun_ff(coreRun_ff),
      .extResetPinN(extResetPinN), .oscDriveEn_ff(oscDriveEn_ff), .wdtReset_ff(wdtReset_ff),
      .deviceReset_ff(deviceReset_ff), .irqFlag(irqFlag), .irqAsyncOk(irqAsyncOk),
      .liveOut(liveOut), .liveOe(liveOe), .pinOut(pinOut), .pinOe(pinOe));
   swc_pipe_model pipe (
      .core_clk(core_clk), .go(go), .pc(pc), .fire(fire), .asyncOk(asyncOk),
      .sleepExec(sleepExec), .wdtClearExec(wdtClearExec), .programCounter(programCounter),
      .irqFlag(irqFlag), .irqAsyncOk(irqAsyncOk));
   initial begin
      core_clk = 0;
      forever #10 core_clk = ~core_clk;
   end
   function [12:0] nxt_pc(input [12:0] p);
      nxt_pc = p + 13'h1;
   endfunction
   task chk(input [31:0] got, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge core_clk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
         @(posedge core_clk) penable <= 1;
         @(posedge core_clk);
         while (pready_ff !== 1'b1) @(posedge core_clk);
         {er, rd} = {pslverr_ff, prdata_ff};
         {psel, penable} <= 2'b00;
      end
   endtask
   task sleep_go;
      begin
         @(posedge core_clk) go <= 1;
         pc <= $random(seed);
         @(posedge core_clk) go <= 0;
         repeat (3) @(posedge core_clk);
      end
   endtask
   task end_of_test;
      begin
         $display("comparisons=%0d mismatches=%0d", cmp_count, mismatches);
         if (mismatches == 0 && cmp_count > 0) begin
            $display("STATUS OK");
         end else begin
            $display("STATUS NOT OK");
         end
         $finish;
      end
   endtask
   initial begin
      #400000;
      mismatches = mismatches + 1;
      end_of_test;
   end
   initial begin
      seed = 32'h6ebd3811;
      {mismatches, cmp_count, sawVec} = 0;
      {nrst, psel, penable, pwrite, go, paddr, pwdata, pc, fire, liveOut, liveOe} = 0;
      asyncOk = 10'h3ff;
      extResetPinN = 1;
      repeat (4) @(posedge core_clk);
      nrst <= 1;
      apb(0, `SWC_STATUS_OFF, 0);
      chk(rd[`SWC_PDF_BIT], 1);
      chk({coreRun_ff, oscDriveEn_ff}, 2'b11);
      apb(0, 12'h0f0, 0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      // Enabled flag already set: sleep degrades to a no-op
      apb(1, `SWC_IRQEN_OFF, 32'h3ff);
      apb(1, `SWC_CTRL_OFF, 0);
      fire <= 10'h004;
      sleep_go;
      chk(oscDriveEn_ff, 1);
      apb(0, `SWC_STATUS_OFF, 0);
      chk(rd[`SWC_TOF_BIT:`SWC_PDF_BIT], 2'b11);
      fire <= 0;
      for (k = 0; k < 10; k = k + 1) begin
         apb(1, `SWC_CTRL_OFF, {30'h0, k[0], 1'b0});
         apb(1, `SWC_IRQEN_OFF, 32'h1 << k);
         held = {liveOe, liveOut};
         sleep_go;
         chk(oscDriveEn_ff, 0);
         chk(fetchAddr_ff, nxt_pc(pc));
         apb(0, `SWC_STATUS_OFF, 0);
         chk(rd[`SWC_TOF_BIT:`SWC_PDF_BIT], 2'b10);
         {liveOe, liveOut} <= $random(seed);
         fire <= 10'h1 << ((k + 1) % 10);
         sawVec = 0;
         repeat (6) @(posedge core_clk);
         chk(oscDriveEn_ff, 0);
         chk({pinOe, pinOut}, held);
         fire <= 10'h1 << k;
         for (i = 0; i < 8 && oscDriveEn_ff !== 1'b1; i = i + 1) @(posedge core_clk);
         repeat (3) begin
            @(posedge core_clk);
            if (vectorTake_ff === 1'b1) sawVec = 1;
         end
         chk({deviceReset_ff, oscDriveEn_ff}, 2'b01);
         chk(sawVec, k[0]);
         fire <= 0;
      end
      asyncOk <= 10'h3f7;
      apb(1, `SWC_IRQEN_OFF, 32'h8);
      sleep_go;
      fire <= 10'h008;
      repeat (6) @(posedge core_clk);
      chk(oscDriveEn_ff, 0);
      asyncOk <= 10'h3ff;
      repeat (4) @(posedge core_clk);
      chk(oscDriveEn_ff, 1);
      fire <= 0;
      // Watchdog wake with all sources masked
      apb(1, `SWC_IRQEN_OFF, 0);
      apb(1, `SWC_CTRL_OFF, 32'h1);
      sleep_go;
      for (i = 0; i < 5000 && oscDriveEn_ff !== 1'b1; i = i + 1) @(posedge core_clk);
      chk({deviceReset_ff, oscDriveEn_ff}, 2'b01);
      apb(0, `SWC_STATUS_OFF, 0);
      chk(rd[`SWC_TOF_BIT:`SWC_PDF_BIT], 2'b00);
      // Awake expiry is a reset request, not a wake
      for (i = 0; i < 5000 && wdtReset_ff !== 1'b1; i = i + 1) @(posedge core_clk);
      chk({wdtReset_ff, oscDriveEn_ff}, 2'b11);
      apb(1, `SWC_CTRL_OFF, 0);
      sleep_go;
      // Reset pin pulled low during sleep for 8 cycles, then released here
      extResetPinN <= 0;
      repeat (8) @(posedge core_clk);
      chk({deviceReset_ff, oscDriveEn_ff}, 2'b11);
      extResetPinN <= 1;
      repeat (8) @(posedge core_clk);
      apb(0, `SWC_STATUS_OFF, 0);
      chk(rd[`SWC_ASLEEP_BIT], 0);
      end_of_test;
   end
endmodule // tb_sleep_wake_controller
